/* File: design/bfc_pkg.sv */
package bfc_pkg;
	// system clock and timing sources
	localparam int CLK_HZ = 100_000_000;
	localparam int SLOW_HZ = 32_768;
	localparam int RING_HZ = 32_000;
	// debounce interval, least time, so it rounds up
	localparam int DEBOUNCE_US = 15_000;
	localparam int DEBOUNCE_TICKS = (DEBOUNCE_US * SLOW_HZ + 999_999) / 1_000_000;
	localparam int DEB_W = 9;
	// ring-derived slow tick, a divider of the system clock
	localparam int RING_DIV = CLK_HZ / RING_HZ;
	localparam int RING_W = 12;
	// slow clock declared absent after this long without an edge
	localparam int SLOW_LOSS_US = 100;
	localparam int SLOW_LOSS_CYC = SLOW_LOSS_US * (CLK_HZ / 1_000_000);
	localparam int LOSS_W = 16;
	// synchroniser bit positions
	localparam int SY_PG = 0;
	localparam int SY_S3 = 1;
	localparam int SY_S5 = 2;
	localparam int SY_BTN = 3;
	localparam int SY_SLOW = 4;
	localparam int SY_W = 5;
	// reset values
	localparam logic RST_HELD = 1'b0;
	localparam logic RST_PRESS_N = 1'b1;
	localparam logic RST_DRIVE = 1'b0;

	typedef enum logic [1:0] {
		BTN_ARMED,
		BTN_LOW_CHECK,
		BTN_PRESSED
	} bfc_btn_e;
endpackage

/* File: design/bfc_sync.sv */
// two-flop synchroniser; the first stage feeds only the second
module bfc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// asynchronous in, synchronous out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	// metastability filter
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			meta_r <= INIT;
			sync_out <= INIT;
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

/* File: design/bfc_top.sv */
// Notes on behaviour
// - drive supply switch low only when power good and S3 input both high.
// - held cut is low whenever S5 input or internal switch signal is low.
// - held cut rises only on switch signal rising edge while S5 already high.
// - switch signal high with no new edge leaves held cut unchanged.
// - press accepted only after pin stable low 15 ms following first fall.
// - after a press, pin must be high 15 ms before next fall arms.
// - falls before the high-stable period completes are ignored.
// - debounce timed from external 32.768 kHz clock when present.
// - without external clock, time from internal ring-derived 32 kHz.
module bfc_top #(
	parameter int LOSS_CYC = bfc_pkg::SLOW_LOSS_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// chipset and supply inputs
	input wire logic psu_power_good,
	input wire logic sleep_s3_n,
	input wire logic sleep_s5_n,
	// power button and slow clock pins
	input wire logic power_button_n,
	input wire logic slow_clock_pin,
	// open-drain supply switch
	output logic supply_switch_out,
	output logic supply_switch_oe,
	// latched cut, debounced button and slow clock presence
	output logic held_supply_cut,
	output logic button_press_n,
	output logic slow_clock_present
);
	// refuse windows and counts the counters cannot hold
	if (LOSS_CYC < 2 * bfc_pkg::RING_DIV || LOSS_CYC >= (1 << bfc_pkg::LOSS_W))
		$error("LOSS_CYC out of range");
	if (bfc_pkg::DEBOUNCE_TICKS >= (1 << bfc_pkg::DEB_W))
		$error("debounce count too wide");
	if (bfc_pkg::RING_DIV > (1 << bfc_pkg::RING_W))
		$error("ring divider too wide");

	localparam logic [bfc_pkg::DEB_W-1:0] DEB_T = bfc_pkg::DEB_W'(bfc_pkg::DEBOUNCE_TICKS);
	localparam logic [bfc_pkg::RING_W-1:0] RING_T = bfc_pkg::RING_W'(bfc_pkg::RING_DIV - 1);
	localparam logic [bfc_pkg::LOSS_W-1:0] LOSS_T = bfc_pkg::LOSS_W'(LOSS_CYC);

	logic [bfc_pkg::SY_W-1:0] sy;
	logic pg_s, s3_s, s5_s, btn_s, slow_s;
	logic switch_n, bf_prev_r, held_nxt;
	logic slow_prev_r, slow_rise;
	logic [bfc_pkg::RING_W-1:0] ring_cnt_r;
	logic ring_tick_r;
	logic [bfc_pkg::LOSS_W-1:0] loss_cnt_r;
	logic tick_r;
	bfc_pkg::bfc_btn_e btn_state_r;
	logic [bfc_pkg::DEB_W-1:0] deb_cnt_r;

	// all pins cross into the clock domain here; button idles high
	bfc_sync #(
		.W(bfc_pkg::SY_W),
		.INIT(5'h08)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.async_in({slow_clock_pin, power_button_n, sleep_s5_n, sleep_s3_n, psu_power_good}),
		.sync_out(sy)
	);

	assign pg_s = sy[bfc_pkg::SY_PG];
	assign s3_s = sy[bfc_pkg::SY_S3];
	assign s5_s = sy[bfc_pkg::SY_S5];
	assign btn_s = sy[bfc_pkg::SY_BTN];
	assign slow_s = sy[bfc_pkg::SY_SLOW];

	// open-drain: the data bit is always low, only the enable moves
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			supply_switch_oe <= bfc_pkg::RST_DRIVE;
			supply_switch_out <= 1'b0;
		end
		else
		begin
			supply_switch_oe <= pg_s & s3_s;
			supply_switch_out <= 1'b0;
		end
	end

	// internal switch level as the pin would show it
	assign switch_n = ~supply_switch_oe;

	// low dominates; set needs a fresh rising edge with S5 high
	assign held_nxt = s5_s & switch_n & (held_supply_cut | ~bf_prev_r);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			bf_prev_r <= 1'b1; // idle switch level, so no false edge after reset
			held_supply_cut <= bfc_pkg::RST_HELD;
		end
		else
		begin
			bf_prev_r <= switch_n;
			held_supply_cut <= held_nxt;
		end
	end

	// slow clock edge detect on the synchronised copy
	assign slow_rise = slow_s & ~slow_prev_r;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			slow_prev_r <= 1'b0;
		else
			slow_prev_r <= slow_s;
	end

	// ring-derived 32 kHz enable, free running
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ring_cnt_r <= '0;
			ring_tick_r <= 1'b0;
		end
		else if (ring_cnt_r == RING_T)
		begin
			ring_cnt_r <= '0;
			ring_tick_r <= 1'b1;
		end
		else
		begin
			ring_cnt_r <= ring_cnt_r + 1'b1;
			ring_tick_r <= 1'b0;
		end
	end

	// presence watchdog; a stuck pin falls back to the ring source
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			loss_cnt_r <= '0;
			slow_clock_present <= 1'b0;
		end
		else if (slow_rise)
		begin
			loss_cnt_r <= '0;
			slow_clock_present <= 1'b1;
		end
		else if (loss_cnt_r == LOSS_T)
			slow_clock_present <= 1'b0;
		else
			loss_cnt_r <= loss_cnt_r + 1'b1;
	end

	// debounce timebase select
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			tick_r <= 1'b0;
		else if (slow_clock_present)
			tick_r <= slow_rise;
		else
			tick_r <= ring_tick_r;
	end

	// button debounce; starts in pressed so a held button must release first
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			btn_state_r <= bfc_pkg::BTN_PRESSED;
			deb_cnt_r <= '0;
			button_press_n <= bfc_pkg::RST_PRESS_N;
		end
		else
		begin
			case (btn_state_r)
				bfc_pkg::BTN_ARMED:
				begin
					deb_cnt_r <= '0;
					if (!btn_s)
						btn_state_r <= bfc_pkg::BTN_LOW_CHECK;
				end
				bfc_pkg::BTN_LOW_CHECK:
				begin
					if (btn_s)
						btn_state_r <= bfc_pkg::BTN_ARMED;
					else if (tick_r && deb_cnt_r == DEB_T)
					begin
						btn_state_r <= bfc_pkg::BTN_PRESSED;
						button_press_n <= 1'b0;
						deb_cnt_r <= '0;
					end
					else if (tick_r)
						deb_cnt_r <= deb_cnt_r + 1'b1;
				end
				bfc_pkg::BTN_PRESSED:
				begin
					if (btn_s)
						button_press_n <= 1'b1;
					if (!btn_s)
						deb_cnt_r <= '0;
					else if (tick_r && deb_cnt_r == DEB_T)
					begin
						btn_state_r <= bfc_pkg::BTN_ARMED;
						deb_cnt_r <= '0;
					end
					else if (tick_r)
						deb_cnt_r <= deb_cnt_r + 1'b1;
				end
				default:
				begin
					btn_state_r <= bfc_pkg::BTN_PRESSED;
					deb_cnt_r <= '0;
				end
			endcase
		end
	end

	drive_when_both_a: assert property (@(posedge clk) disable iff (reset)
		(pg_s && s3_s) |=> (supply_switch_oe && !supply_switch_out))
		else $error("switch not driven with power good and S3 high");

	release_when_not_a: assert property (@(posedge clk) disable iff (reset)
		!(pg_s && s3_s) |=> !supply_switch_oe)
		else $error("switch driven outside power good and S3 high");

	cut_low_a: assert property (@(posedge clk) disable iff (reset)
		(!s5_s || supply_switch_oe) |=> !held_supply_cut)
		else $error("held cut high while S5 or switch low");

	cut_set_a: assert property (@(posedge clk) disable iff (reset)
		$rose(held_supply_cut)
		|-> ($past(s5_s) && !$past(supply_switch_oe) && !$past(bf_prev_r)))
		else $error("held cut rose without a qualified edge");

	cut_hold_a: assert property (@(posedge clk) disable iff (reset)
		(s5_s && switch_n && bf_prev_r) |=> (held_supply_cut == $past(held_supply_cut)))
		else $error("held cut changed without a new edge");

	press_min_a: assert property (@(posedge clk) disable iff (reset)
		$fell(button_press_n) |-> ($past(btn_state_r) == bfc_pkg::BTN_LOW_CHECK
			&& $past(deb_cnt_r) == DEB_T && $past(tick_r)))
		else $error("press accepted before full low interval");

	rearm_high_a: assert property (@(posedge clk) disable iff (reset)
		(btn_state_r == bfc_pkg::BTN_PRESSED ##1 btn_state_r == bfc_pkg::BTN_ARMED)
		|-> ($past(deb_cnt_r, 1) == DEB_T && $past(tick_r, 1) && $past(btn_s, 1)))
		else $error("rearmed before full high interval");

	ignore_fall_a: assert property (@(posedge clk) disable iff (reset)
		(btn_state_r == bfc_pkg::BTN_PRESSED && !btn_s)
		|=> (btn_state_r == bfc_pkg::BTN_PRESSED && deb_cnt_r == '0))
		else $error("fall during release interval not ignored");

	ext_tick_a: assert property (@(posedge clk) disable iff (reset)
		(slow_clock_present && slow_rise) |=> tick_r)
		else $error("slow clock edge did not tick");

	ring_tick_a: assert property (@(posedge clk) disable iff (reset)
		(!slow_clock_present && !ring_tick_r) |=> !tick_r)
		else $error("tick without ring source while clock absent");

	slow_loss_a: assert property (@(posedge clk) disable iff (reset)
		(loss_cnt_r == LOSS_T && !slow_rise) |=> !slow_clock_present)
		else $error("missing slow clock not detected");
endmodule

/* File: test/bfc_chipset_model.sv */
// chipset sleep lines, supply power good and free-running slow clock
module bfc_chipset_model #(
	parameter int HALF = 5,
	parameter int T3_MIN = 3_000,
	parameter int T4_MIN = 100_000
) (
	// clock
	clk,
	// observed switch enable and slow clock run control
	switch_oe,
	slow_en,
	// lines driven toward the device
	psu_power_good,
	sleep_s3_n,
	sleep_s5_n,
	slow_clock_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	input wire logic clk;
	input wire logic switch_oe;
	input wire logic slow_en;
	output logic psu_power_good = 1'b0;
	output logic sleep_s3_n = 1'b1;
	output logic sleep_s5_n = 1'b1;
	output logic slow_clock_pin = 1'b0;
	int sw_age = 1_000_000;
	int s5_age = 1_000_000;
	int half_cnt = 0;

	// ages since the switch let go and since s5 returned, saturating
	always @(posedge clk)
	begin
		sw_age <= switch_oe ? 0 : (sw_age < 1_000_000 ? sw_age + 1 : sw_age);
		s5_age <= !sleep_s5_n ? 0 : (s5_age < 1_000_000 ? s5_age + 1 : s5_age);
	end

	// slow clock runs free while enabled, holds its level when stopped
	always @(posedge clk)
	begin
		if (slow_en)
		begin
			half_cnt <= (half_cnt == HALF - 1) ? 0 : half_cnt + 1;
			if (half_cnt == HALF - 1)
				slow_clock_pin <= ~slow_clock_pin;
		end
	end

	// change lines at an edge, keeping the system's own spacing
	task set_lines(input logic pg, input logic s3, input logic s5);
		while (!s5 && sleep_s5_n && sw_age < T3_MIN) @(posedge clk);
		while (pg && s3 && s5 && s5_age < T4_MIN) @(posedge clk);
		@(posedge clk);
		psu_power_good <= pg;
		sleep_s3_n <= s3;
		sleep_s5_n <= s5;
	endtask
endmodule

/* File: test/bfc_top_tb.sv */
module bfc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// slow clock sped up so a debounce interval fits the run
	localparam int LOSS = 6300;
	localparam int TICK = 10;
	localparam int DEB = 493 * TICK;
	// rows: power good, s3, s5, expected enable, expected held cut
	localparam logic [4:0] ROWS [7] = '{5'h04, 5'h14, 5'h0c, 5'h1e, 5'h15, 5'h10, 5'h14};
	localparam int WAITS [7] = '{6, 6, 6, 6, 4000, 6, 6};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic power_button_n = 1'b1;
	logic slow_en = 1'b1;
	logic pg;
	logic s3;
	logic s5;
	logic slow;
	logic sw_out;
	logic sw_oe;
	logic held;
	logic press_n;
	logic present;
	int n_errors = 0;
	int n_compared = 0;

	bfc_chipset_model #(.HALF(TICK / 2)) bfc_chipset_model_i (.clk(clk), .switch_oe(sw_oe),
		.slow_en(slow_en), .psu_power_good(pg), .sleep_s3_n(s3), .sleep_s5_n(s5),
		.slow_clock_pin(slow));
	bfc_top #(.LOSS_CYC(LOSS)) bfc_top_i (.clk(clk), .reset(reset), .psu_power_good(pg),
		.sleep_s3_n(s3), .sleep_s5_n(s5), .power_button_n(power_button_n),
		.slow_clock_pin(slow), .supply_switch_out(sw_out), .supply_switch_oe(sw_oe),
		.held_supply_cut(held), .button_press_n(press_n), .slow_clock_present(present));

	// system clock
	initial
	begin
		forever #5 clk = ~clk;
	end

	// compare once the edge's updates have landed
	task chk(input string name, input logic exp, input logic got);
		#1;
		n_compared++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %b seen %b", name, exp, got);
			n_errors++;
		end
	endtask

	task hold_btn(input logic v, input int n);
		@(posedge clk);
		power_button_n <= v;
		repeat (n) @(posedge clk);
	endtask

	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// cut a hang well past the expected run length
	initial
	begin
		repeat (60_000) @(posedge clk);
		n_errors++;
		print_verdict();
	end

	initial
	begin
		repeat (16) @(posedge clk);
		// release at the edge; no further edge yet, so outputs still show reset values
		reset <= 1'b0;
		chk("supply_switch_oe", 1'b0, sw_oe);
		chk("held_supply_cut", 1'b0, held);
		chk("button_press_n", 1'b1, press_n);
		$display("test reset done");
		// switch truth table, then a normal power-down with s5 returning
		for (int i = 0; i < 7; i++)
		begin
			bfc_chipset_model_i.set_lines(ROWS[i][4], ROWS[i][3], ROWS[i][2]);
			repeat (WAITS[i]) @(posedge clk);
			chk("supply_switch_oe", ROWS[i][1], sw_oe);
			chk("supply_switch_out", 1'b0, sw_out);
			chk("held_supply_cut", ROWS[i][0], held);
		end
		$display("test supply switch done");
		// button held high from reset arms, then a press just short and past
		hold_btn(1'b1, DEB + 100);
		chk("slow_clock_present", 1'b1, present);
		hold_btn(1'b0, 480 * TICK);
		chk("button_press_n", 1'b1, press_n);
		repeat (20 * TICK) @(posedge clk);
		chk("button_press_n", 1'b0, press_n);
		hold_btn(1'b1, 10);
		chk("button_press_n", 1'b1, press_n);
		// bounce and an early fall before the high interval is complete
		hold_btn(1'b1, 300 * TICK);
		hold_btn(1'b0, 5);
		hold_btn(1'b1, 300 * TICK);
		hold_btn(1'b0, 600 * TICK);
		chk("button_press_n", 1'b1, press_n);
		hold_btn(1'b1, DEB + 100);
		hold_btn(1'b0, DEB + 100);
		chk("button_press_n", 1'b0, press_n);
		$display("test button done");
		// stop the slow clock so timing falls back to the ring source
		hold_btn(1'b1, 10);
		slow_en <= 1'b0;
		repeat (LOSS + 100) @(posedge clk);
		chk("slow_clock_present", 1'b0, present);
		$display("test slow clock loss done");
		// reset again mid-run with s5 high; held cut must not see a false edge
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		chk("supply_switch_oe", 1'b0, sw_oe);
		chk("slow_clock_present", 1'b0, present);
		repeat (6) @(posedge clk);
		chk("held_supply_cut", 1'b0, held);
		chk("button_press_n", 1'b1, press_n);
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule
